//--- inc/sesr_pkg.sv
// constants shared by the alignment, slot gate and status register block
package sesr_pkg;
  localparam int ADDR_W = 4;
  localparam int DATA_W = 16;
  localparam int CNT_W  = 18;
  localparam int SNAP_W = 12;
  localparam int SLOT_N = 8;
  localparam int SLOT_W = 3;
  localparam int SUB_W  = 2;

  // clock and output periods in their own units
  localparam int CLK_PERIOD_NS = 4;
  localparam int T_125US_NS    = 125000;
  localparam int T_250US_NS    = 250000;
  localparam int T_500US_NS    = 500000;
  localparam int T_1MS_NS      = 1000000;
  localparam int CYC_125US     = T_125US_NS / CLK_PERIOD_NS;
  localparam int CYC_250US     = T_250US_NS / CLK_PERIOD_NS;
  localparam int CYC_500US     = T_500US_NS / CLK_PERIOD_NS;
  localparam int CYC_1MS       = T_1MS_NS / CLK_PERIOD_NS;

  // register offsets
  localparam logic [ADDR_W-1:0] ADDR_SNAPSHOT = 4'h7;
  localparam logic [ADDR_W-1:0] ADDR_CONFIG   = 4'h8;
  localparam logic [ADDR_W-1:0] ADDR_ALIGN    = 4'hb;
  localparam logic [ADDR_W-1:0] ADDR_SLOT     = 4'he;
  localparam logic [ADDR_W-1:0] ADDR_SECONDARY_STATUS  = 4'hf;

  // field positions
  localparam int SYNC_BIT   = 0;
  localparam int SNAP_BIT   = 1;
  localparam int RATE_LSB   = 4;
  localparam int RATE_MSB   = 5;
  localparam int VER_MSB    = 2;
  localparam int MISSED_BIT = 3;

  // output rate select codes
  localparam logic [1:0] RATE_125US = 2'h0;
  localparam logic [1:0] RATE_250US = 2'h1;
  localparam logic [1:0] RATE_500US = 2'h2;
  localparam logic [1:0] RATE_1MS   = 2'h3;

  // reset values
  localparam logic [SLOT_N-1:0] SLOT_RST = 8'hff;
  localparam logic [1:0]        RATE_RST = 2'h0;
  localparam logic [SNAP_W-1:0] SNAP_RST = 12'h000;
  // version code is arbitrary
  localparam logic [VER_MSB:0]  VERSION_DEF = 3'h5;
endpackage : sesr_pkg

//--- sim/sesr_host_model.sv
// host model that reads the sample outputs a while after each strobe
`timescale 1ns/10ps
module sesr_host_model (
  input  wire logic       clk,
  input  wire logic       rst,
  input  wire logic       strobe,
  input  wire logic       rd_en,
  input  wire logic [4:0] rd_dly,
  output logic            sample_rd
);
  int wait_n;
  // reads only while enabled, so a missed period can be commanded
  always @(negedge clk) begin
    if (rst) begin
      sample_rd <= 1'b0;
      wait_n = -1;
    end else begin
      sample_rd <= 1'b0;
      if (strobe && rd_en) wait_n = rd_dly;
      else if (wait_n > 0) wait_n--;
      else if (wait_n == 0) begin
        sample_rd <= 1'b1;
        wait_n = -1;
      end
    end
  end
endmodule : sesr_host_model

//--- sim/test_sync_emi_status_regs.sv
// self-checking bench for the alignment, slot gate and status registers
`timescale 1ns/10ps
module test_sync_emi_status_regs;
  import sesr_pkg::*;
  logic        clk = 1'b0, rst = 1'b1, wr = 1'b0, rd = 1'b0, bc = 1'b0;
  logic        smp, pwm = 1'b0, gated, align, strobe, rd_d = 1'b0;
  logic        rd_en = 1'b1, p;
  logic [3:0]  addr = 4'h0;
  logic [15:0] wdata = 16'h0000, rdata, ver;
  logic [4:0]  rd_dly = 5'h03;
  logic [31:0] rs = 32'h0000002b;
  logic [15:0] q_exp[$], q_msk[$], msk;
  int          n_fail = 0, n_compared = 0, nt[4] = '{40, 80, 160, 320}, k;

  always #2 clk = ~clk;

  sesr_regs #(.P_CYC_125US(40), .P_CYC_250US(80), .P_CYC_500US(160),
    .P_CYC_1MS(320)) i_dut (.CLK(clk), .RST(rst), .REG_WR(wr), .REG_RD(rd),
    .REG_BCAST(bc), .REG_ADDR(addr), .REG_WDATA(wdata), .REG_RDATA(rdata),
    .SAMPLE_RD(smp), .PWM_REQ(pwm), .PWM_GATED(gated),
    .ALIGN_PULSE(align), .OUTPUT_STROBE(strobe));

  sesr_host_model i_host (.clk(clk), .rst(rst), .strobe(strobe),
    .rd_en(rd_en), .rd_dly(rd_dly), .sample_rd(smp));

  function logic [31:0] xs();
    rs = rs ^ (rs << 13);
    rs = rs ^ (rs >> 17);
    rs = rs ^ (rs << 5);
    return rs;
  endfunction : xs

  task automatic cmp_reg(string what, logic [15:0] e, logic [15:0] g);
    n_compared++;
    if (g !== e) begin
      n_fail++;
      $display("wrong value %s expected %h seen %h", what, e, g);
    end
  endtask : cmp_reg

  task automatic cmp_bit(string what, logic e, logic g);
    n_compared++;
    if (g !== e) begin
      n_fail++;
      $display("wrong value %s expected %b seen %b", what, e, g);
    end
  endtask : cmp_bit

  task automatic cmp_cnt(string what, int e, int g);
    n_compared++;
    if (g != e) begin
      n_fail++;
      $display("wrong value %s expected %0d seen %0d", what, e, g);
    end
  endtask : cmp_cnt

  task automatic reg_wr(logic [3:0] a, logic [15:0] d, logic b);
    @(negedge clk);
    wr = 1'b1;
    bc = b;
    addr = a;
    wdata = d;
    @(negedge clk);
    wr = 1'b0;
    bc = 1'b0;
  endtask : reg_wr

  task automatic reg_rd(logic [3:0] a, logic [15:0] e, logic [15:0] m);
    q_exp.push_back(e);
    q_msk.push_back(m);
    @(negedge clk);
    rd = 1'b1;
    addr = a;
    @(negedge clk);
    rd = 1'b0;
  endtask : reg_rd

  // counts negedges until the next strobe, bounded
  task automatic gap(output int n);
    n = 0;
    do begin
      @(negedge clk);
      n++;
    end while (strobe !== 1'b1 && n < 2000);
  endtask : gap

  // read data is checked one cycle after each read strobe
  always @(posedge clk) rd_d <= rd;
  always @(negedge clk) begin
    if (rd_d && q_exp.size() > 0) begin
      msk = q_msk.pop_front();
      cmp_reg("read data", q_exp.pop_front() & msk, rdata & msk);
    end
  end

  task automatic wrap_up();
    $display("compared %0d failed %0d", n_compared, n_fail);
    if (n_fail == 0 && n_compared > 0) $display("verification passed");
    else $display("verification failed");
    $finish;
  endtask : wrap_up

  initial begin
    #40000;
    n_fail++;
    wrap_up();
  end

  initial begin
    ver = {13'h0000, VERSION_DEF};
    repeat (10) @(posedge clk);
    @(negedge clk) rst = 1'b0;
    reg_rd(ADDR_SLOT, 16'h00ff, 16'hffff);
    reg_rd(ADDR_SECONDARY_STATUS, ver, 16'hffff);
    reg_rd(ADDR_SNAPSHOT, 16'h0000, 16'hffff);
    reg_rd(4'h3, 16'h0000, 16'hffff);
    reg_wr(ADDR_SECONDARY_STATUS, 16'(xs()), 1'b0);
    reg_wr(ADDR_SNAPSHOT, 16'(xs()), 1'b1);
    reg_rd(ADDR_SECONDARY_STATUS, ver, 16'h0007);
    reg_rd(ADDR_SNAPSHOT, 16'h0000, 16'hffff);
    reg_wr(ADDR_ALIGN, 16'h0001, 1'b0);
    // a pulse would already stand as the write task returns
    k = int'(align === 1'b1);
    repeat (4) @(negedge clk) k += int'(align === 1'b1);
    cmp_cnt("align without broadcast", 0, k);
    for (int r = 0; r < 4; r++) begin
      reg_wr(ADDR_CONFIG, 16'(r << RATE_LSB), 1'b0);
      reg_wr(ADDR_ALIGN, 16'h0001, 1'b1);
      k = 0;
      while (align !== 1'b1 && k < 8) @(negedge clk) k++;
      cmp_bit("align pulse", 1'b1, align);
      @(negedge clk);
      cmp_bit("align width", 1'b0, align);
      gap(k);
      cmp_cnt("align to strobe", nt[r], k);
      gap(k);
      cmp_cnt("strobe period", nt[r], k);
      reg_rd(ADDR_CONFIG, 16'(r << RATE_LSB), 16'hffff);
    end
    reg_wr(ADDR_CONFIG, 16'h0000, 1'b0);
    reg_wr(ADDR_ALIGN, 16'h0001, 1'b1);
    // counter restarts on alignment; the snap write right behind it sees 1
    reg_wr(ADDR_ALIGN, 16'h0002, 1'b1);
    reg_rd(ADDR_ALIGN, 16'h0000, 16'hffff);
    reg_rd(ADDR_SNAPSHOT, 16'h0001, 16'hffff);
    reg_rd(ADDR_SECONDARY_STATUS, ver, 16'h0007);
    rd_en = 1'b0;
    repeat (2) gap(k);
    @(negedge clk);
    reg_rd(ADDR_SECONDARY_STATUS, ver | 16'h0008, 16'hffff);
    reg_rd(ADDR_SECONDARY_STATUS, ver, 16'hffff);
    rd_en = 1'b1;
    rd_dly = 5'(xs());
    gap(k);
    @(negedge clk);
    reg_rd(ADDR_SECONDARY_STATUS, ver, 16'h0007);
    gap(k);
    @(negedge clk);
    reg_rd(ADDR_SECONDARY_STATUS, ver, 16'hffff);
    pwm = 1'(xs());
    repeat (64) begin
      p = pwm;
      @(negedge clk);
      cmp_bit("gated pulse", p, gated);
      pwm = 1'(xs());
    end
    pwm = 1'b1;
    for (int b = 0; b < 9; b++) begin
      reg_wr(ADDR_SLOT, 16'(b < 8 ? 1 << b : 0), 1'b0);
      repeat (4) @(negedge clk);
      k = 0;
      repeat (32) @(negedge clk) k += int'(gated === 1'b1);
      cmp_cnt("gated slots", b < 8 ? 4 : 0, k);
    end
    repeat (4) @(negedge clk);
    wrap_up();
  end
endmodule : test_sync_emi_status_regs

//--- verilog/sesr_period.sv
// output period timer; restarts on an alignment pulse
`timescale 1ns/10ps
module sesr_period #(
  parameter int P_CYC_125US = sesr_pkg::CYC_125US,
  parameter int P_CYC_250US = sesr_pkg::CYC_250US,
  parameter int P_CYC_500US = sesr_pkg::CYC_500US,
  parameter int P_CYC_1MS   = sesr_pkg::CYC_1MS
) (
  input  wire logic                       clk,
  input  wire logic                       rst,
  input  wire logic                       sync,
  input  wire logic [1:0]                 rate_sel,
  output logic                            tick,
  output logic [sesr_pkg::SNAP_W-1:0]     cnt_low
);
  import sesr_pkg::*;

  logic [CNT_W-1:0] cnt_r;
  logic [CNT_W-1:0] cnt_nxt;
  logic [CNT_W-1:0] last;
  logic             tick_r;
  logic             tick_nxt;

  always_comb begin
    case (rate_sel)
      RATE_125US: last = CNT_W'(P_CYC_125US - 1);
      RATE_250US: last = CNT_W'(P_CYC_250US - 1);
      RATE_500US: last = CNT_W'(P_CYC_500US - 1);
      default:    last = CNT_W'(P_CYC_1MS - 1);
    endcase
  end

  always_comb begin
    tick_nxt = 1'b0;
    // alignment restarts the period so all devices emit together
    if (sync) begin
      cnt_nxt = '0;
    end else if (cnt_r >= last) begin
      cnt_nxt  = '0;
      tick_nxt = 1'b1;
    end else begin
      cnt_nxt = cnt_r + CNT_W'(1);
    end
  end

  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      cnt_r  <= '0;
      tick_r <= 1'b0;
    end else begin
      cnt_r  <= cnt_nxt;
      tick_r <= tick_nxt;
    end
  end

  assign tick    = tick_r;
  assign cnt_low = cnt_r[SNAP_W-1:0];

  // independent check of the period length for the 125us select code
  property p_period_len;
    @(posedge clk) disable iff (rst)
    (!sync && cnt_r == CNT_W'(P_CYC_125US - 1) && rate_sel == RATE_125US)
      |=> tick_r && cnt_r == '0;
  endproperty
  a_period_len: assert property (p_period_len)
    else $error("output period did not end at the selected length");
endmodule : sesr_period

//--- verilog/sesr_regs.sv
// alignment, converter slot gate and secondary status registers
// Notes on behaviour
// - broadcast write of bit 0 at 0xb aligns output timing of devices
// - after alignment each device emits outputs at the same instant
// - broadcast write of bit 1 at 0xb latches the sync counter
// - both alignment bits clear themselves one clock after being set
// - slot bits gate converter pulses per clock/4 slot; reset all ones
// - an output period with no sample read sets the missed-read flag
// - reading the secondary status register clears the missed-read flag
// - latched counter sits in bits 11:0 at 0x7; upper bits reserved
// - output period follows the rate field: 125us, 250us, 500us, 1ms
`timescale 1ns/10ps
module sesr_regs #(
  parameter int                          P_CYC_125US = sesr_pkg::CYC_125US,
  parameter int                          P_CYC_250US = sesr_pkg::CYC_250US,
  parameter int                          P_CYC_500US = sesr_pkg::CYC_500US,
  parameter int                          P_CYC_1MS   = sesr_pkg::CYC_1MS,
  parameter logic [sesr_pkg::VER_MSB:0]  P_VERSION   = sesr_pkg::VERSION_DEF
) (
  input  wire logic                          CLK,
  input  wire logic                          RST,
  input  wire logic                          REG_WR,
  input  wire logic                          REG_RD,
  input  wire logic                          REG_BCAST,
  input  wire logic [sesr_pkg::ADDR_W-1:0]   REG_ADDR,
  input  wire logic [sesr_pkg::DATA_W-1:0]   REG_WDATA,
  output logic      [sesr_pkg::DATA_W-1:0]   REG_RDATA,
  input  wire logic                          SAMPLE_RD,
  input  wire logic                          PWM_REQ,
  output logic                               PWM_GATED,
  output logic                               ALIGN_PULSE,
  output logic                               OUTPUT_STROBE
);
  import sesr_pkg::*;

  logic                wr_align;
  logic                rd_status;
  logic                sync_r;
  logic                sync_nxt;
  logic                snap_r;
  logic                snap_nxt;
  logic [SNAP_W-1:0]   snapshot_r;
  logic [SNAP_W-1:0]   snapshot_nxt;
  logic [SLOT_N-1:0]   slot_gate_r;
  logic [SLOT_N-1:0]   slot_gate_nxt;
  logic [1:0]          rate_r;
  logic [1:0]          rate_nxt;
  logic                missed_r;
  logic                missed_nxt;
  logic                seen_r;
  logic                seen_nxt;
  logic [SLOT_W+SUB_W-1:0] phase_r;
  logic [SLOT_W+SUB_W-1:0] phase_nxt;
  logic [SLOT_W-1:0]   slot;
  logic                gated_r;
  logic                gated_nxt;
  logic [DATA_W-1:0]   rdata_r;
  logic [DATA_W-1:0]   rdata_nxt;
  logic                tick;
  logic [SNAP_W-1:0]   cnt_low;
  logic                miss_evt;

  sesr_period #(
    .P_CYC_125US (P_CYC_125US),
    .P_CYC_250US (P_CYC_250US),
    .P_CYC_500US (P_CYC_500US),
    .P_CYC_1MS   (P_CYC_1MS)
  ) u_period (
    .clk      (CLK),
    .rst      (RST),
    .sync     (sync_r),
    .rate_sel (rate_r),
    .tick     (tick),
    .cnt_low  (cnt_low)
  );

  assign wr_align  = REG_WR && REG_BCAST && (REG_ADDR == ADDR_ALIGN);
  assign rd_status = REG_RD && (REG_ADDR == ADDR_SECONDARY_STATUS);
  assign slot      = phase_r[SLOT_W+SUB_W-1:SUB_W];
  assign miss_evt  = tick && !seen_r && !SAMPLE_RD;

  // control and snapshot state
  always_comb begin
    // alignment bits only honour broadcast writes, then fall back to zero
    sync_nxt      = wr_align && REG_WDATA[SYNC_BIT];
    snap_nxt      = wr_align && REG_WDATA[SNAP_BIT];
    snapshot_nxt  = snap_r ? cnt_low : snapshot_r;
    slot_gate_nxt = slot_gate_r;
    rate_nxt      = rate_r;
    if (REG_WR && REG_ADDR == ADDR_SLOT) begin
      slot_gate_nxt = REG_WDATA[SLOT_N-1:0];
    end
    if (REG_WR && REG_ADDR == ADDR_CONFIG) begin
      rate_nxt = REG_WDATA[RATE_MSB:RATE_LSB];
    end
  end

  always_ff @(posedge CLK or posedge RST) begin
    if (RST) begin
      sync_r      <= 1'b0;
      snap_r      <= 1'b0;
      snapshot_r  <= SNAP_RST;
      slot_gate_r <= SLOT_RST;
      rate_r      <= RATE_RST;
    end else begin
      sync_r      <= sync_nxt;
      snap_r      <= snap_nxt;
      snapshot_r  <= snapshot_nxt;
      slot_gate_r <= slot_gate_nxt;
      rate_r      <= rate_nxt;
    end
  end

  // missed-read tracking; a new miss beats a same-cycle clear by read
  always_comb begin
    seen_nxt   = seen_r || SAMPLE_RD;
    missed_nxt = missed_r;
    if (tick) begin
      seen_nxt = 1'b0;
    end
    if (rd_status) begin
      missed_nxt = 1'b0;
    end
    if (miss_evt) begin
      missed_nxt = 1'b1;
    end
  end

  always_ff @(posedge CLK or posedge RST) begin
    if (RST) begin
      seen_r   <= 1'b0;
      missed_r <= 1'b0;
    end else begin
      seen_r   <= seen_nxt;
      missed_r <= missed_nxt;
    end
  end

  // clock/4 slot phase; alignment also realigns the slot sequence
  always_comb begin
    phase_nxt = sync_r ? '0 : phase_r + (SLOT_W+SUB_W)'(1);
    gated_nxt = PWM_REQ && slot_gate_r[slot];
  end

  always_ff @(posedge CLK or posedge RST) begin
    if (RST) begin
      phase_r <= '0;
      gated_r <= 1'b0;
    end else begin
      phase_r <= phase_nxt;
      gated_r <= gated_nxt;
    end
  end

  // read data, one cycle after the read strobe; flag value before clearing
  always_comb begin
    rdata_nxt = rdata_r;
    if (REG_RD) begin
      rdata_nxt = '0;
      case (REG_ADDR)
        ADDR_SNAPSHOT: rdata_nxt[SNAP_W-1:0] = snapshot_r;
        ADDR_CONFIG:   rdata_nxt[RATE_MSB:RATE_LSB] = rate_r;
        ADDR_ALIGN: begin
          rdata_nxt[SYNC_BIT] = sync_r;
          rdata_nxt[SNAP_BIT] = snap_r;
        end
        ADDR_SLOT:     rdata_nxt[SLOT_N-1:0] = slot_gate_r;
        ADDR_SECONDARY_STATUS: begin
          rdata_nxt[VER_MSB:0]  = P_VERSION;
          rdata_nxt[MISSED_BIT] = missed_r;
        end
        default:       rdata_nxt = '0;
      endcase
    end
  end

  always_ff @(posedge CLK or posedge RST) begin
    if (RST) begin
      rdata_r <= '0;
    end else begin
      rdata_r <= rdata_nxt;
    end
  end

  assign REG_RDATA     = rdata_r;
  assign PWM_GATED     = gated_r;
  assign ALIGN_PULSE   = sync_r;
  assign OUTPUT_STROBE = tick;

  property p_sync_set;
    @(posedge CLK) disable iff (RST)
    (wr_align && REG_WDATA[SYNC_BIT]) |=> sync_r;
  endproperty
  a_sync_set: assert property (p_sync_set)
    else $error("broadcast alignment write gave no pulse");

  property p_self_clear;
    @(posedge CLK) disable iff (RST)
    (sync_r || snap_r) && !wr_align |=> !sync_r && !snap_r;
  endproperty
  a_self_clear: assert property (p_self_clear)
    else $error("alignment bit held longer than one cycle");

  property p_align_restart;
    @(posedge CLK) disable iff (RST)
    sync_r |=> cnt_low == '0 ##1 (cnt_low == SNAP_W'(1) || $past(sync_r));
  endproperty
  a_align_restart: assert property (p_align_restart)
    else $error("period did not restart after alignment");

  property p_snap_latch;
    @(posedge CLK) disable iff (RST)
    snap_r |=> snapshot_r == $past(cnt_low);
  endproperty
  a_snap_latch: assert property (p_snap_latch)
    else $error("snapshot did not capture the counter");

  property p_snap_read;
    @(posedge CLK) disable iff (RST)
    (REG_RD && REG_ADDR == ADDR_SNAPSHOT) |=>
      REG_RDATA == DATA_W'($past(snapshot_r));
  endproperty
  a_snap_read: assert property (p_snap_read)
    else $error("snapshot readback wrong");

  property p_gate;
    @(posedge CLK) disable iff (RST)
    PWM_REQ && !slot_gate_r[slot] |=> !PWM_GATED;
  endproperty
  a_gate: assert property (p_gate)
    else $error("pulse passed a disabled slot");

  property p_miss_set;
    @(posedge CLK) disable iff (RST)
    miss_evt |=> missed_r;
  endproperty
  a_miss_set: assert property (p_miss_set)
    else $error("missed period not flagged");

  property p_read_clear;
    @(posedge CLK) disable iff (RST)
    rd_status && !miss_evt |=> !missed_r ##0 REG_RDATA[MISSED_BIT] ==
      $past(missed_r);
  endproperty
  a_read_clear: assert property (p_read_clear)
    else $error("status read did not clear the flag");

  property p_version;
    @(posedge CLK) disable iff (RST)
    rd_status |=> REG_RDATA[VER_MSB:0] == P_VERSION &&
      REG_RDATA[DATA_W-1:MISSED_BIT+1] == '0;
  endproperty
  a_version: assert property (p_version)
    else $error("version or reserved bits wrong");

  c_sync:   cover property (@(posedge CLK) disable iff (RST) sync_r);
  c_snap:   cover property (@(posedge CLK) disable iff (RST) snap_r);
  c_missed: cover property (@(posedge CLK) disable iff (RST) miss_evt);
  c_gated:  cover property (@(posedge CLK) disable iff (RST)
                            PWM_REQ && !slot_gate_r[slot]);
endmodule : sesr_regs
